// [src/ppb_dev.sv]
// Device end: register port, pointer access, page selection and packet header decode
// Notes on behaviour
// - Reads prefetch into temp, never stall host; the host sequencer here still waits on busy before each data access
// - Writes land in temp, committed later
// - Setup bit 0 halves arbitration rate
// - Host loads pointer high, then low
// - Data repeated; pointer readable for count
// - Buffer RAM is four 512-byte pages
// - Two-bit page field selects page 0-3
// - Offset bit 5 adds 256 bytes
// - Command 0010 0011 sends upper page 0
// - Start is page*512 plus f*256
// - No page bound check on receive
// - Long packets need 512-byte receive pages
// - Short-only allows 256-byte half pages
// - Pointer at 02/03, data 04, autoincrement
// - Bytes: source, destination, count or zero
// - Byte 2 zero means long; byte 3 count
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
module ppb_dev (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  ppb_if.dev               bus,
  input  wire logic        eng_req,
  input  wire logic        eng_we,
  input  wire logic        eng_rx,
  input  wire logic [9:0]  eng_idx,
  input  wire logic [7:0]  eng_wdata,
  output logic             eng_ack,
  output logic [7:0]       eng_rdata,
  output logic             tx_go,
  output logic             rx_go,
  output logic [10:0]      tx_start,
  output logic [10:0]      rx_start,
  output logic             pkt_long,
  output logic             pkt_bcast,
  output logic [7:0]       pkt_src,
  output logic [9:0]       data_ofs
);
  logic [7:0]  first_setup;
  logic [7:0]  ptr_hi;
  logic [10:0] ptr;
  logic        rdmode;
  logic        autoinc;
  logic [7:0]  temp;
  logic        pend;
  logic        pend_we;
  logic [7:0]  rd_val;
  logic        h_ack;
  logic [7:0]  ram_q;
  logic        e_ack;
  logic [10:0] e_addr;
  logic [10:0] next_start;
  logic [7:0]  e_byte;
  logic        wr_cmd;
  logic        wr_lo;
  logic        wr_data;
  logic        rd_data;

  assign wr_cmd  = bus.wr && (bus.addr == ppb_pkg::OFF_CMD);
  assign wr_lo   = bus.wr && (bus.addr == ppb_pkg::OFF_PTR_LO);
  assign wr_data = bus.wr && (bus.addr == ppb_pkg::OFF_DATA);
  assign rd_data = bus.rd && (bus.addr == ppb_pkg::OFF_DATA);

  // First setup register
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      first_setup <= ppb_pkg::FSETUP_RESET;
    else if (bus.wr && bus.addr == ppb_pkg::OFF_FSETUP)
      first_setup <= bus.wdata;

  // Pointer high is only staged; the low write is what loads the address
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ptr_hi <= 8'h00;
    else if (bus.wr && bus.addr == ppb_pkg::OFF_PTR_HI)
      ptr_hi <= bus.wdata;

  // Pointer and mode bits; 11-bit add wraps past the top to zero
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ptr     <= 11'h000;
      rdmode  <= 1'b0;
      autoinc <= 1'b0;
    end
    else if (wr_lo)
    begin
      ptr     <= {ptr_hi[ppb_pkg::PTRH_ADDR_HI:0], bus.wdata};
      rdmode  <= ptr_hi[ppb_pkg::PTRH_RDMODE];
      autoinc <= ptr_hi[ppb_pkg::PTRH_AUTOINC];
    end
    else if (autoinc && ((rd_data && rdmode) || (h_ack && pend_we)))
      ptr <= ptr + 11'h001;

  // Outstanding RAM job for the temporary register
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pend    <= 1'b0;
      pend_we <= 1'b0;
    end
    else if (wr_data)
    begin
      pend    <= 1'b1;
      pend_we <= 1'b1;
    end
    else if ((wr_lo && ptr_hi[ppb_pkg::PTRH_RDMODE]) || (rd_data && rdmode && autoinc))
    begin
      pend    <= 1'b1;
      pend_we <= 1'b0;
    end
    else if (h_ack)
      pend <= 1'b0;

  // Temporary register: host byte on write, prefetched byte on read
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      temp <= 8'h00;
    else if (wr_data)
      temp <= bus.wdata;
    else if (h_ack && !pend_we)
      temp <= ram_q;

  // Readback mux; data reads return temp at once, never waiting on arbitration
  always_comb
  begin
    case (bus.addr)
      ppb_pkg::OFF_PTR_HI: rd_val = {rdmode, autoinc, 3'h0, ptr[10:8]};
      ppb_pkg::OFF_PTR_LO: rd_val = ptr[7:0];
      ppb_pkg::OFF_DATA:   rd_val = temp;
      ppb_pkg::OFF_FSETUP: rd_val = first_setup;
      default:             rd_val = 8'h00;
    endcase
  end

  // Register read data
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      bus.rdata <= 8'h00;
    else if (bus.rd)
      bus.rdata <= rd_val;

  assign bus.busy = pend;

  // Page start: page number times 512 plus half-page offset
  always_comb
  begin
    next_start = ppb_pkg::PAGE_BYTES * {9'h000, bus.wdata[ppb_pkg::CMD_PG_HI:ppb_pkg::CMD_PG_LO]};
    if (bus.wdata[ppb_pkg::CMD_F])
      next_start = next_start + ppb_pkg::HALF_PAGE;
  end

  // Enable transmit and enable receive commands
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_start <= 11'h000;
      rx_start <= 11'h000;
      tx_go    <= 1'b0;
      rx_go    <= 1'b0;
    end
    else
    begin
      tx_go <= wr_cmd && (bus.wdata[2:0] == ppb_pkg::CMD_TX);
      rx_go <= wr_cmd && (bus.wdata[2:0] == ppb_pkg::CMD_RX);
      if (wr_cmd && bus.wdata[2:0] == ppb_pkg::CMD_TX)
        tx_start <= next_start;
      if (wr_cmd && bus.wdata[2:0] == ppb_pkg::CMD_RX)
        rx_start <= next_start;
    end

  // Engine address: base plus index, no page limit, wraps in the RAM
  assign e_addr = (eng_rx ? rx_start : tx_start) + {1'b0, eng_idx};
  assign e_byte = eng_we ? eng_wdata : ram_q;

  // Header decode as the engine moves header bytes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pkt_src   <= 8'h00;
      pkt_bcast <= 1'b0;
      pkt_long  <= 1'b0;
      data_ofs  <= 10'h000;
    end
    else if (e_ack)
    begin
      if (eng_idx == ppb_pkg::PKT_SRC)
        pkt_src <= e_byte;
      if (eng_idx == ppb_pkg::PKT_DST)
        pkt_bcast <= (e_byte == ppb_pkg::BCAST_ID);
      if (eng_idx == ppb_pkg::PKT_CNT)
      begin
        pkt_long <= (e_byte == 8'h00);
        data_ofs <= {2'b00, e_byte};
      end
      if (eng_idx == ppb_pkg::PKT_LCNT && pkt_long)
        data_ofs <= ppb_pkg::LONG_DATA_OFS + {2'b00, e_byte};
    end

  // Engine read data and acknowledge come straight off RAM flops
  assign eng_ack   = e_ack;
  assign eng_rdata = ram_q;

  // Shared buffer RAM and its arbiter
  ppb_buf_ram ppb_buf_ram_i (
    .hclk    (hclk),
    .hresetn (hresetn),
    .slow    (first_setup[ppb_pkg::FSETUP_SLOW_ARB]),
    .h_req   (pend),
    .h_we    (pend_we),
    .h_addr  (ptr),
    .h_wdata (temp),
    .h_ack   (h_ack),
    .e_req   (eng_req),
    .e_we    (eng_we),
    .e_addr  (e_addr),
    .e_wdata (eng_wdata),
    .e_ack   (e_ack),
    .rdata   (ram_q)
  );
endmodule : ppb_dev

// [include/ppb_pkg.sv]
// Shared constants and types for the paged packet buffer access block
package ppb_pkg;
  // Register port offsets seen by the host
  localparam logic [2:0] OFF_CMD    = 3'h1;
  localparam logic [2:0] OFF_PTR_HI = 3'h2;
  localparam logic [2:0] OFF_PTR_LO = 3'h3;
  localparam logic [2:0] OFF_DATA   = 3'h4;
  localparam logic [2:0] OFF_FSETUP = 3'h6;
  // Pointer high register fields
  localparam int PTRH_RDMODE  = 7;
  localparam int PTRH_AUTOINC = 6;
  localparam int PTRH_ADDR_HI = 2;
  // First setup register fields and reset value
  localparam int         FSETUP_SLOW_ARB = 0;
  localparam logic [7:0] FSETUP_RESET    = 8'h00;
  // Command word fields
  localparam int         CMD_F     = 5;
  localparam int         CMD_PG_HI = 4;
  localparam int         CMD_PG_LO = 3;
  localparam logic [2:0] CMD_TX    = 3'h3;
  localparam logic [2:0] CMD_RX    = 3'h4;
  // Buffer geometry: four pages of 512 bytes, half-page step of 256
  localparam int          RAM_AW     = 11;
  localparam int          RAM_DEPTH  = 2048;
  localparam int          NUM_PAGES  = 4;
  localparam logic [10:0] PAGE_BYTES = 11'h200;
  localparam logic [10:0] HALF_PAGE  = 11'h100;
  // Packet layout inside a buffer
  localparam logic [9:0] PKT_SRC       = 10'h000;
  localparam logic [9:0] PKT_DST       = 10'h001;
  localparam logic [9:0] PKT_CNT       = 10'h002;
  localparam logic [9:0] PKT_LCNT      = 10'h003;
  localparam logic [9:0] LONG_DATA_OFS = 10'h100;
  localparam logic [7:0] BCAST_ID      = 8'h00;
  // Controller registers on the AHB-Lite side
  localparam logic [7:0] HREG_ACCESS  = 8'h00;
  localparam logic [7:0] HREG_STATUS  = 8'h04;
  localparam logic [7:0] HREG_PTRLOAD = 8'h08;
  localparam int         ACC_OFF_LO   = 8;
  localparam int         ACC_RD       = 16;
  localparam int         PTRL_AUTOINC = 16;
  localparam int         PTRL_RDMODE  = 17;
  // Controller sequencer states
  typedef enum logic [2:0] {H_IDLE, H_HI, H_LO, H_ACC, H_WAIT} ppb_hstate_e;
endpackage : ppb_pkg

// [include/ppb_if.sv]
// Parallel register port between the host controller and the buffer device
interface ppb_if;
  logic [2:0] addr;   // Register offset
  logic [7:0] wdata;  // Write data
  logic       wr;     // One-cycle write strobe
  logic       rd;     // One-cycle read strobe
  logic [7:0] rdata;  // Read data, valid the cycle after rd
  logic       busy;   // Temporary register still owed to the RAM

  modport dev (input addr, input wdata, input wr, input rd, output rdata, output busy);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input busy);
endinterface : ppb_if

// [src/ppb_buf_ram.sv]
// Buffer RAM with two-port arbitration and optional slow arbitration tick
module ppb_buf_ram (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        slow,
  input  wire logic        h_req,
  input  wire logic        h_we,
  input  wire logic [10:0] h_addr,
  input  wire logic [7:0]  h_wdata,
  output logic             h_ack,
  input  wire logic        e_req,
  input  wire logic        e_we,
  input  wire logic [10:0] e_addr,
  input  wire logic [7:0]  e_wdata,
  output logic             e_ack,
  output logic [7:0]       rdata
);
  logic [7:0] mem [ppb_pkg::RAM_DEPTH];
  logic       half;
  logic       last_host;
  logic       tick;
  logic       free;
  logic       go_h;
  logic       go_e;

  // Slow mode grants only on every second edge, halving the arbitration rate
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      half <= 1'b0;
    else
      half <= ~half;

  assign tick = slow ? half : 1'b1;
  // No new grant while an ack is out, so a requester can drop its request
  assign free = tick & ~h_ack & ~e_ack;
  // Alternate on contention so neither side starves
  assign go_h = free & h_req & (~e_req | ~last_host);
  assign go_e = free & e_req & ~go_h;

  // Grant and acknowledge
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      h_ack     <= 1'b0;
      e_ack     <= 1'b0;
      last_host <= 1'b0;
    end
    else
    begin
      h_ack <= go_h;
      e_ack <= go_e;
      if (go_h | go_e)
        last_host <= go_h;
    end

  // Storage; data out is registered with the ack
  always_ff @(posedge hclk)
  begin
    if (go_h && h_we)
      mem[h_addr] <= h_wdata;
    else if (go_e && e_we)
      mem[e_addr] <= e_wdata;
    if (go_h)
      rdata <= mem[h_addr];
    else if (go_e)
      rdata <= mem[e_addr];
  end
endmodule : ppb_buf_ram

// [src/ppb_host.sv]
// Host end: AHB-Lite controller that runs register cycles on the parallel port
module ppb_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  ppb_if.host              bus
);
  ppb_pkg::ppb_hstate_e state;
  logic       wph;
  logic       rph;
  logic [7:0] waddr;
  logic [7:0] raddr;
  logic [2:0] acc_off;
  logic [7:0] acc_wd;
  logic       acc_rd;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;
  logic [7:0] last_rd;
  logic       start_acc;
  logic       start_ptr;

  assign start_acc = wph && state == ppb_pkg::H_IDLE && waddr == ppb_pkg::HREG_ACCESS;
  assign start_ptr = wph && state == ppb_pkg::H_IDLE && waddr == ppb_pkg::HREG_PTRLOAD;

  // Address phase capture; reads add one wait state so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wph       <= 1'b0;
      rph       <= 1'b0;
      waddr     <= 8'h00;
      raddr     <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end
    else
    begin
      wph <= hready && hsel && htrans[1] && hwrite;
      rph <= hready && hsel && htrans[1] && !hwrite;
      if (hready && hsel && htrans[1])
      begin
        waddr <= haddr[7:0];
        raddr <= haddr[7:0];
      end
      hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
      if (rph)
      begin
        case (raddr)
          ppb_pkg::HREG_STATUS:
            hrdata <= {16'h0000, last_rd, 6'h00, bus.busy, state != ppb_pkg::H_IDLE};
          default:
            hrdata <= 32'h0000_0000;
        endcase
      end
    end

  // Orders from software; refused while a sequence runs
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      acc_off <= 3'h0;
      acc_wd  <= 8'h00;
      acc_rd  <= 1'b0;
      hi_byte <= 8'h00;
      lo_byte <= 8'h00;
    end
    else if (start_acc)
    begin
      acc_wd  <= hwdata[7:0];
      acc_off <= hwdata[ppb_pkg::ACC_OFF_LO +: 3];
      acc_rd  <= hwdata[ppb_pkg::ACC_RD];
    end
    else if (start_ptr)
    begin
      hi_byte <= {hwdata[ppb_pkg::PTRL_RDMODE], hwdata[ppb_pkg::PTRL_AUTOINC], 3'h0, hwdata[10:8]};
      lo_byte <= hwdata[7:0];
    end

  // Port sequencer: pointer high then low, data cycles wait for the temp register
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      state     <= ppb_pkg::H_IDLE;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= 3'h0;
      bus.wdata <= 8'h00;
      last_rd   <= 8'h00;
    end
    else
    begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      case (state)
        ppb_pkg::H_IDLE:
          if (start_acc)
            state <= ppb_pkg::H_ACC;
          else if (start_ptr)
            state <= ppb_pkg::H_HI;
        ppb_pkg::H_HI:
          if (!bus.busy)
          begin
            bus.wr    <= 1'b1;
            bus.addr  <= ppb_pkg::OFF_PTR_HI;
            bus.wdata <= hi_byte;
            state     <= ppb_pkg::H_LO;
          end
        ppb_pkg::H_LO:
        begin
          bus.wr    <= 1'b1;
          bus.addr  <= ppb_pkg::OFF_PTR_LO;
          bus.wdata <= lo_byte;
          state     <= ppb_pkg::H_IDLE;
        end
        ppb_pkg::H_ACC:
          if (!bus.busy)
          begin
            bus.wr    <= !acc_rd;
            bus.rd    <= acc_rd;
            bus.addr  <= acc_off;
            bus.wdata <= acc_wd;
            state     <= acc_rd ? ppb_pkg::H_WAIT : ppb_pkg::H_IDLE;
          end
        // Device read data appears only after the strobe's own edge, so skip that edge
        ppb_pkg::H_WAIT:
          if (!bus.rd)
          begin
            last_rd <= bus.rdata;
            state   <= ppb_pkg::H_IDLE;
          end
        default:
          state <= ppb_pkg::H_IDLE;
      endcase
    end
endmodule : ppb_host

// [testbench/ppb_chk.sv]
// Checker for the register port between the host controller and the buffer device
module ppb_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hi_val;
  logic [7:0] lo_val;
  logic       clean;

  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Staged pointer bytes; readback is predictable only until a data access moves the pointer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hi_val <= 8'h00;
      lo_val <= 8'h00;
      clean  <= 1'b0;
    end
    else if (wr && addr == ppb_pkg::OFF_PTR_HI)
    begin
      hi_val <= wdata;
      clean  <= 1'b0;
    end
    else if (wr && addr == ppb_pkg::OFF_PTR_LO)
    begin
      lo_val <= wdata;
      clean  <= 1'b1;
    end
    else if ((wr || rd) && addr == ppb_pkg::OFF_DATA)
      clean <= 1'b0;
  end

  // Strobes and the temporary register
  chk_strobe_excl: assert property (!(wr && rd))
    else $error("write and read strobes overlap");
  chk_write_busy: assert property (wr && addr == ppb_pkg::OFF_DATA |=> busy)
    else $error("data write not held in temporary register");
  chk_load_prefetch: assert property
    (wr && addr == ppb_pkg::OFF_PTR_LO && hi_val[ppb_pkg::PTRH_RDMODE] |=> busy)
    else $error("pointer load in read mode started no prefetch");
  chk_busy_bound: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("temporary register never committed");
  chk_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  chk_idle_access: assert property
    ((rd || wr) && addr == ppb_pkg::OFF_DATA || wr && addr == ppb_pkg::OFF_PTR_LO |-> !busy)
    else $error("data access or pointer load while busy");

  // Pointer readback after a load
  chk_hi_readback: assert property (rd && addr == ppb_pkg::OFF_PTR_HI && clean
    |=> rdata == {hi_val[7:6], 3'b000, hi_val[2:0]})
    else $error("pointer high readback wrong");
  chk_lo_readback: assert property (rd && addr == ppb_pkg::OFF_PTR_LO && clean
    |=> rdata == lo_val)
    else $error("pointer low readback wrong");

  cover property (wr && addr == ppb_pkg::OFF_DATA);
  cover property (rd && addr == ppb_pkg::OFF_DATA);
  cover property (wr && addr == ppb_pkg::OFF_PTR_LO && hi_val[ppb_pkg::PTRH_RDMODE]);
  cover property (rd && addr == ppb_pkg::OFF_PTR_LO && clean);
endmodule : ppb_chk

// [testbench/paged_packet_buffer_access_tb_top.sv]
// Testbench top: AHB and engine stimulus against a behavioural buffer model
module paged_packet_buffer_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        eng_req, eng_we, eng_rx, eng_ack, tx_go, rx_go, pkt_long, pkt_bcast;
  logic [9:0]  eng_idx, data_ofs;
  logic [7:0]  eng_wdata, eng_rdata, pkt_src, b, v0, v2, v3;
  logic [10:0] tx_start, rx_start;
  int          miscompares, tests_run, n_tx, n_rx, s, tx_m, rx_m;
  int          mem_m [2048];

  ppb_if ppb_if_i ();
  ppb_host ppb_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(ppb_if_i.host));
  ppb_dev ppb_dev_i (.hclk(hclk), .hresetn(hresetn), .bus(ppb_if_i.dev), .eng_req(eng_req),
    .eng_we(eng_we), .eng_rx(eng_rx), .eng_idx(eng_idx), .eng_wdata(eng_wdata),
    .eng_ack(eng_ack), .eng_rdata(eng_rdata), .tx_go(tx_go), .rx_go(rx_go),
    .tx_start(tx_start), .rx_start(rx_start), .pkt_long(pkt_long), .pkt_bcast(pkt_bcast),
    .pkt_src(pkt_src), .data_ofs(data_ofs));
  ppb_chk ppb_chk_i (.hclk(hclk), .hresetn(hresetn), .addr(ppb_if_i.addr),
    .wdata(ppb_if_i.wdata), .wr(ppb_if_i.wr), .rd(ppb_if_i.rd), .rdata(ppb_if_i.rdata),
    .busy(ppb_if_i.busy));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Go pulses last one cycle, so the falling edge sees each exactly once
  always @(negedge hclk)
  begin
    if (tx_go === 1'b1) n_tx++;
    if (rx_go === 1'b1) n_rx++;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One single AHB transfer; entered and left just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    @(posedge hclk);
  endtask : ahb

  // Poll until the sequencer is idle; a write while busy would be dropped
  task automatic seq_wait();
    do ahb(1'b0, 8'h04, 32'h0); while (r[0] !== 1'b0);
  endtask : seq_wait

  task automatic dev_wr(input logic [2:0] off, input logic [7:0] d);
    ahb(1'b1, 8'h00, {21'h0, off, d});
    seq_wait();
  endtask : dev_wr

  task automatic dev_rd(input logic [2:0] off);
    ahb(1'b1, 8'h00, {15'h0, 1'b1, 5'h0, off, 8'h00});
    seq_wait();
    b = r[15:8];
  endtask : dev_rd

  task automatic ptr_ld(input logic rdm, input logic ai, input int a);
    ahb(1'b1, 8'h08, {14'h0, rdm, ai, 5'h0, 11'(a)});
    seq_wait();
  endtask : ptr_ld

  // Engine access; the model folds base plus index into 11 bits with no page check
  task automatic eng(input logic we, input logic rx, input logic [9:0] idx, input logic [7:0] d);
    int a;
    a = ((rx ? rx_m : tx_m) + int'(idx)) % 2048;
    eng_req   <= 1'b1;
    eng_we    <= we;
    eng_rx    <= rx;
    eng_idx   <= idx;
    eng_wdata <= d;
    do @(negedge hclk); while (eng_ack !== 1'b1);
    b = eng_rdata;
    @(posedge hclk);
    eng_req <= 1'b0;
    @(posedge hclk);
    if (we) mem_m[a] = d;
    else chk("eng_rdata", mem_m[a], b);
  endtask : eng

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    final_report();
  end

  initial
  begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {eng_req, eng_we, eng_rx, eng_idx, eng_wdata} = '0;
    {miscompares, tests_run, n_tx, n_rx} = '0;
    void'($urandom(68727));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h04, 32'h0);
    chk("status_reset", 32'h0, r);
    ahb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, r);
    // Bursts across the top of the RAM, fast then slow arbitration
    for (int sl = 0; sl < 2; sl++)
    begin
      dev_wr(ppb_pkg::OFF_FSETUP, 8'(sl));
      s = 2044 + sl;
      ptr_ld(1'b0, 1'b1, s);
      for (int i = 0; i < 8; i++)
      begin
        v0 = 8'($urandom);
        mem_m[(s + i) % 2048] = v0;
        dev_wr(ppb_pkg::OFF_DATA, v0);
      end
      dev_rd(ppb_pkg::OFF_PTR_LO);
      chk("ptr_lo", (s + 8) % 256, b);
      dev_rd(ppb_pkg::OFF_PTR_HI);
      chk("ptr_hi", 8'h40 | ((s + 8) % 2048) / 256, b);
      ptr_ld(1'b1, 1'b1, s);
      for (int i = 0; i < 8; i++)
      begin
        dev_rd(ppb_pkg::OFF_DATA);
        chk("data_rd", mem_m[(s + i) % 2048], b);
      end
      dev_rd(ppb_pkg::OFF_PTR_HI);
      chk("ptr_hi_rd", 8'hc0 | ((s + 8) % 2048) / 256, b);
    end
    // Every page and half for both commands
    for (int c = 0; c < 16; c++)
    begin
      dev_wr(ppb_pkg::OFF_CMD, {2'b00, c[0], c[2:1], c[3] ? ppb_pkg::CMD_RX : ppb_pkg::CMD_TX});
      s = int'(c[2:1]) * 512 + int'(c[0]) * 256;
      chk(c[3] ? "rx_start" : "tx_start", s, c[3] ? rx_start : tx_start);
    end
    chk("tx_go", 8, n_tx);
    chk("rx_go", 8, n_rx);
    tx_m = 1792;
    rx_m = 1792;
    eng(1'b0, 1'b0, 10'h0fc, 8'h00);
    dev_wr(ppb_pkg::OFF_CMD, 8'h23);
    chk("tx_start_23", 32'h100, tx_start);
    tx_m = 256;
    // Long packets may arrive, so receive goes to a whole page
    dev_wr(ppb_pkg::OFF_CMD, 8'h1c);
    chk("rx_start_1c", 32'h600, rx_start);
    rx_m = 1536;
    // Headers: long broadcast, then short addressed
    for (int k = 0; k < 2; k++)
    begin
      v0 = 8'($urandom);
      v2 = 8'($urandom) | 8'h01;
      v3 = 8'($urandom);
      eng(1'b1, 1'b1, 10'h000, v0);
      eng(1'b1, 1'b1, 10'h001, k ? v2 : 8'h00);
      eng(1'b1, 1'b1, 10'h002, k ? v2 : 8'h00);
      eng(1'b1, 1'b1, 10'h003, v3);
      chk("pkt_long", k ? 0 : 1, pkt_long);
      chk("pkt_bcast", k ? 0 : 1, pkt_bcast);
      chk("pkt_src", v0, pkt_src);
      chk("data_ofs", k ? v2 : 256 + v3, data_ofs);
      eng(1'b0, 1'b1, 10'h003, 8'h00);
    end
    // Receive past the page end wraps to the bottom of the RAM without complaint
    v0 = 8'($urandom);
    eng(1'b1, 1'b1, 10'h3ff, v0);
    ptr_ld(1'b1, 1'b0, 511);
    dev_rd(ppb_pkg::OFF_PTR_HI);
    chk("ptr_hi_ld", 8'h81, b);
    dev_rd(ppb_pkg::OFF_PTR_LO);
    chk("ptr_lo_ld", 8'hff, b);
    dev_rd(ppb_pkg::OFF_DATA);
    chk("rx_overrun", v0, b);
    final_report();
  end
endmodule : paged_packet_buffer_access_tb_top
